// ==== src/aeqc_top.sv ====
// adaptive equalizer control: registers, sweep sequencer and error checking
// Operation
// - filter upper limit bits 7:4, reset 0xA
// - filter lower limit bits 3:0, reset 0x9
// - filter setting kept within limits while lower <= upper
// - error select bits 6:4 enable checks
// - errors counted over half relock period
// - count above threshold raises equalizer setting
// - two-step mode validates candidates with errors
// - bit 3 picks filter sweep start point
// - one-step waits full period, checks lock
// - two-step waits half, then monitors half
// - error in second step advances immediately
// - bit 1 picks which sweep is outer
// - bit 0 enables filter sweeping, reset 1
// - error threshold 8 bits, reset 1, nonzero
`timescale 1ns/1ps
`include "aeqc_defines.svh"
module aeqc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [`AEQC_PERIOD_W-1:0] relock_period,
  input wire logic adapt_start,
  input wire logic link_lock,
  input wire logic err_clock_bit,
  input wire logic err_sequence,
  input wire logic err_parity,
  output logic [3:0] eq_setting,
  output logic [3:0] sample_phase_filter,
  output logic adapt_busy,
  output logic adapt_locked
);
  // -------------------------------------------------------------------
  // configuration from the register file
  // -------------------------------------------------------------------
  logic [3:0] hi;
  logic [3:0] lo;
  logic [2:0] err_sel;
  logic order;
  logic two_step;
  logic nesting;
  logic sweep_en;
  logic [7:0] threshold;

  aeqc_regs u_aeqc_regs (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .phase_filter_upper_limit(hi),
    .phase_filter_lower_limit(lo),
    .adapt_error_check_select(err_sel),
    .filter_sweep_order(order),
    .two_step_validation_enable(two_step),
    .loop_nesting_select(nesting),
    .filter_sweep_enable(sweep_en),
    .adapt_error_threshold(threshold)
  );

  // -------------------------------------------------------------------
  // state and timing
  // -------------------------------------------------------------------
  aeqc_pkg::aeqc_ctl_t s;
  aeqc_pkg::aeqc_ctl_t next_s;
  logic [`AEQC_PERIOD_W-1:0] half_len;
  logic [`AEQC_PERIOD_W-1:0] full_len;
  logic [`AEQC_PERIOD_W-1:0] wait_len;
  logic settle_done;
  logic half_done;
  logic acc_clear;
  logic window_end;
  logic err_seen;
  logic over_threshold;
  logic [3:0] hi_eff;
  logic [3:0] start_filt;
  logic [3:0] adv_eq;
  logic [3:0] adv_filt;

  // full and half periods from the relock period, never below one cycle
  assign half_len = (relock_period[`AEQC_PERIOD_W-1:1] == 19'h0) ? 20'h00001 :
                    {1'h0, relock_period[`AEQC_PERIOD_W-1:1]};
  assign full_len = (relock_period == 20'h00000) ? 20'h00001 : relock_period;
  assign wait_len = two_step ? half_len : full_len;
  assign settle_done = s.timer >= wait_len - 20'h00001;
  assign half_done = s.timer >= half_len - 20'h00001;

  // -------------------------------------------------------------------
  // error accumulation
  // -------------------------------------------------------------------
  // counting runs only while watching a locked link in the monitor state
  assign acc_clear = (s.fsm != aeqc_pkg::AEQC_MONITOR);
  assign window_end = (s.fsm == aeqc_pkg::AEQC_MONITOR) && half_done;

  aeqc_err_acc u_aeqc_err_acc (
    .core_clk(core_clk),
    .rst(rst),
    .clear(acc_clear),
    .window_end(window_end),
    .err_vec({err_clock_bit, err_sequence, err_parity}),
    .err_select(err_sel),
    .threshold(threshold),
    .err_seen(err_seen),
    .over_threshold(over_threshold),
    .err_count()
  );

  // -------------------------------------------------------------------
  // filter helpers
  // -------------------------------------------------------------------
  // keep a setting inside the programmed window
  function automatic logic [3:0] clamp_filt(input logic [3:0] f, input logic [3:0] l, input logic [3:0] h);
    logic [3:0] r;
    r = f;
    if (f > h) begin
      r = h;
    end
    if (r < l) begin
      r = l;
    end
    return r;
  endfunction

  // next filter candidate, wrapping inside the window
  function automatic logic [3:0] step_filt(input logic [3:0] f, input logic [3:0] l, input logic [3:0] h,
                                           input logic ord);
    logic [3:0] r;
    r = f;
    if (!ord) begin
      r = (f <= l) ? h : f - 4'h1;
    end else begin
      r = (f >= h) ? l : f + 4'h1;
    end
    return r;
  endfunction

  // upper limit capped to the legal top, and the sweep start point
  assign hi_eff = (hi > `AEQC_FILTER_TOP) ? `AEQC_FILTER_TOP : hi;
  assign start_filt = order ? clamp_filt(`AEQC_FILTER_CENTRE, lo, hi_eff) : hi_eff;

  // -------------------------------------------------------------------
  // next candidate of the two nested sweeps
  // -------------------------------------------------------------------
  always_comb begin
    adv_eq = s.eq;
    adv_filt = s.filt;
    if (!sweep_en) begin
      adv_eq = (s.eq >= `AEQC_EQ_TOP) ? `AEQC_EQ_BOT : s.eq + 4'h1;
    end else if (!nesting) begin
      // equalizer inner, filter steps when the equalizer wraps
      if (s.eq >= `AEQC_EQ_TOP) begin
        adv_eq = `AEQC_EQ_BOT;
        adv_filt = step_filt(s.filt, lo, hi_eff, order);
      end else begin
        adv_eq = s.eq + 4'h1;
      end
    end else begin
      // filter inner, equalizer steps when the filter sweep closes
      if (step_filt(s.filt, lo, hi_eff, order) == start_filt) begin
        adv_filt = start_filt;
        adv_eq = (s.eq >= `AEQC_EQ_TOP) ? `AEQC_EQ_BOT : s.eq + 4'h1;
      end else begin
        adv_filt = step_filt(s.filt, lo, hi_eff, order);
      end
    end
  end

  // -------------------------------------------------------------------
  // adaptation sequencer
  // -------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.timer = s.timer + 20'h00001;
    case (s.fsm)
      aeqc_pkg::AEQC_IDLE: begin
        next_s.timer = 20'h00000;
      end
      aeqc_pkg::AEQC_SETTLE: begin
        if (settle_done) begin
          next_s.timer = 20'h00000;
          if (!link_lock) begin
            next_s.eq = adv_eq;
            next_s.filt = adv_filt;
          end else if (two_step) begin
            next_s.fsm = aeqc_pkg::AEQC_CHECK;
          end else begin
            next_s.fsm = aeqc_pkg::AEQC_MONITOR;
          end
        end
      end
      aeqc_pkg::AEQC_CHECK: begin
        if (err_seen || (half_done && !link_lock)) begin
          next_s.fsm = aeqc_pkg::AEQC_SETTLE;
          next_s.timer = 20'h00000;
          next_s.eq = adv_eq;
          next_s.filt = adv_filt;
        end else if (half_done) begin
          next_s.fsm = aeqc_pkg::AEQC_MONITOR;
          next_s.timer = 20'h00000;
        end
      end
      aeqc_pkg::AEQC_MONITOR: begin
        if (!link_lock) begin
          next_s.fsm = aeqc_pkg::AEQC_SETTLE;
          next_s.timer = 20'h00000;
          next_s.eq = adv_eq;
          next_s.filt = adv_filt;
        end else if (over_threshold && s.eq < `AEQC_EQ_TOP) begin
          next_s.fsm = aeqc_pkg::AEQC_SETTLE;
          next_s.timer = 20'h00000;
          next_s.eq = s.eq + 4'h1;
        end else if (window_end) begin
          next_s.timer = 20'h00000;
        end
      end
      default: begin
        next_s.fsm = aeqc_pkg::AEQC_IDLE;
      end
    endcase
    // a start request restarts the sweep from its first candidate
    if (adapt_start) begin
      next_s.fsm = aeqc_pkg::AEQC_SETTLE;
      next_s.timer = 20'h00000;
      next_s.eq = `AEQC_EQ_BOT;
      next_s.filt = sweep_en ? start_filt : s.filt;
    end
    // host keeps lo <= hi; the clamp is then the window itself
    next_s.filt = clamp_filt(next_s.filt, lo, hi_eff);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s.fsm <= aeqc_pkg::AEQC_IDLE;
      s.eq <= `AEQC_EQ_BOT;
      s.filt <= `AEQC_FILTER_CENTRE;
      s.timer <= 20'h00000;
    end else begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign eq_setting = s.eq;
  assign sample_phase_filter = s.filt;
  assign adapt_busy = (s.fsm == aeqc_pkg::AEQC_SETTLE) || (s.fsm == aeqc_pkg::AEQC_CHECK);
  assign adapt_locked = (s.fsm == aeqc_pkg::AEQC_MONITOR);

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_filter_in_window: assert property ($past(lo) <= $past(hi_eff) && !$past(rst) |->
    sample_phase_filter >= $past(lo) && sample_phase_filter <= $past(hi_eff))
    else $error("filter setting outside limits");
  a_one_step_waits: assert property (s.fsm == aeqc_pkg::AEQC_SETTLE && !two_step && !settle_done
    && !adapt_start |=> s.fsm == aeqc_pkg::AEQC_SETTLE && s.timer == $past(s.timer) + 20'h00001)
    else $error("one-step settle left early");
  a_one_step_lock: assert property (s.fsm == aeqc_pkg::AEQC_SETTLE && !two_step && settle_done
    && link_lock && !adapt_start |=> s.fsm == aeqc_pkg::AEQC_MONITOR)
    else $error("locked one-step candidate not accepted");
  a_two_step_check: assert property (s.fsm == aeqc_pkg::AEQC_SETTLE && two_step && settle_done
    && link_lock && !adapt_start |=> s.fsm == aeqc_pkg::AEQC_CHECK && s.timer == 20'h00000)
    else $error("two-step did not enter error check");
  a_check_error_skips: assert property (s.fsm == aeqc_pkg::AEQC_CHECK && err_seen && !adapt_start
    |=> s.fsm == aeqc_pkg::AEQC_SETTLE && s.timer == 20'h00000) else $error("error in check not acted on");
  a_check_holds_clean: assert property (s.fsm == aeqc_pkg::AEQC_CHECK && !err_seen && !half_done
    && !adapt_start |=> s.fsm == aeqc_pkg::AEQC_CHECK) else $error("clean check left early");
  a_raise_on_errors: assert property (s.fsm == aeqc_pkg::AEQC_MONITOR && over_threshold && link_lock
    && s.eq < 4'hf && !adapt_start |=> eq_setting == $past(eq_setting) + 4'h1)
    else $error("equalizer not raised on errors");
  a_start_order_top: assert property (adapt_start && sweep_en && !order && lo <= hi_eff
    |=> sample_phase_filter == $past(hi_eff) && eq_setting == 4'h0) else $error("sweep start point wrong");
  a_inner_equalizer: assert property (s.fsm == aeqc_pkg::AEQC_SETTLE && settle_done && !link_lock
    && sweep_en && !nesting && s.eq < 4'hf && !adapt_start && $stable(lo) && $stable(hi)
    |=> eq_setting == $past(eq_setting) + 4'h1 && $stable(sample_phase_filter))
    else $error("equalizer not inner loop");
  a_no_filter_sweep: assert property (s.fsm != aeqc_pkg::AEQC_IDLE && !sweep_en && $stable(lo)
    && $stable(hi) |=> $stable(sample_phase_filter)) else $error("filter moved while disabled");
  a_check_pass: assert property (s.fsm == aeqc_pkg::AEQC_CHECK && half_done && link_lock && !err_seen
    && !adapt_start |=> s.fsm == aeqc_pkg::AEQC_MONITOR && s.timer == 20'h00000)
    else $error("clean two-step candidate not accepted");
  a_window_restart: assert property (s.fsm == aeqc_pkg::AEQC_MONITOR && window_end && link_lock
    && !over_threshold && !adapt_start |=> s.fsm == aeqc_pkg::AEQC_MONITOR && s.timer == 20'h00000)
    else $error("error window did not restart");

  c_one_step_lock: cover property (s.fsm == aeqc_pkg::AEQC_SETTLE && !two_step ##1 s.fsm == aeqc_pkg::AEQC_MONITOR);
  c_two_step_reject: cover property (s.fsm == aeqc_pkg::AEQC_CHECK && err_seen);
  c_two_step_accept: cover property (s.fsm == aeqc_pkg::AEQC_CHECK ##1 s.fsm == aeqc_pkg::AEQC_MONITOR);
  c_readapt: cover property (s.fsm == aeqc_pkg::AEQC_MONITOR && over_threshold);
endmodule

// ==== src/aeqc_defines.svh ====
// register offsets, field positions, reset values and limits of the equalizer control block
`ifndef AEQC_DEFINES_SVH
`define AEQC_DEFINES_SVH
// -------------------------------------------------------------------
// register offsets
// -------------------------------------------------------------------
`define AEQC_ADDR_RSVD_A 8'h40
`define AEQC_ADDR_FILTER 8'h41
`define AEQC_ADDR_CTL 8'h42
`define AEQC_ADDR_THRESH 8'h43
// -------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------
`define AEQC_UPPER_MSB 7
`define AEQC_UPPER_LSB 4
`define AEQC_LOWER_MSB 3
`define AEQC_LOWER_LSB 0
`define AEQC_ERRSEL_MSB 6
`define AEQC_ERRSEL_LSB 4
`define AEQC_ORDER_BIT 3
`define AEQC_TWO_STEP_BIT 2
`define AEQC_NESTING_BIT 1
`define AEQC_SWEEP_EN_BIT 0
// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define AEQC_UPPER_RST 4'ha
`define AEQC_LOWER_RST 4'h9
`define AEQC_ERRSEL_RST 3'h7
`define AEQC_ORDER_RST 1'h0
`define AEQC_TWO_STEP_RST 1'h0
`define AEQC_NESTING_RST 1'h0
`define AEQC_SWEEP_EN_RST 1'h1
`define AEQC_THRESH_RST 8'h01
// -------------------------------------------------------------------
// setting ranges and timer width
// -------------------------------------------------------------------
`define AEQC_FILTER_CENTRE 4'h7
`define AEQC_FILTER_TOP 4'he
`define AEQC_EQ_BOT 4'h0
`define AEQC_EQ_TOP 4'hf
`define AEQC_PERIOD_W 20
`endif

// ==== src/aeqc_pkg.sv ====
// state types of the equalizer control block
package aeqc_pkg;
  // -------------------------------------------------------------------
  // adaptation sequencer
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    AEQC_IDLE,
    AEQC_SETTLE,
    AEQC_CHECK,
    AEQC_MONITOR
  } aeqc_state_t;

  typedef struct packed {
    aeqc_state_t fsm;
    logic [3:0] eq;
    logic [3:0] filt;
    logic [19:0] timer;
  } aeqc_ctl_t;

  // -------------------------------------------------------------------
  // register file and error accumulator
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] upper;
    logic [3:0] lower;
    logic [2:0] err_sel;
    logic order;
    logic two_step;
    logic nesting;
    logic sweep_en;
    logic [7:0] threshold;
    logic [7:0] rdata;
  } aeqc_reg_t;

  typedef struct packed {
    logic [7:0] count;
    logic over;
  } aeqc_acc_t;
endpackage

// ==== src/aeqc_regs.sv ====
// register file of the equalizer control block
`timescale 1ns/1ps
`include "aeqc_defines.svh"
module aeqc_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [3:0] phase_filter_upper_limit,
  output logic [3:0] phase_filter_lower_limit,
  output logic [2:0] adapt_error_check_select,
  output logic filter_sweep_order,
  output logic two_step_validation_enable,
  output logic loop_nesting_select,
  output logic filter_sweep_enable,
  output logic [7:0] adapt_error_threshold
);
  aeqc_pkg::aeqc_reg_t s;
  aeqc_pkg::aeqc_reg_t next_s;

  // -------------------------------------------------------------------
  // write decode and registered read data
  // -------------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (reg_wr) begin
      case (reg_addr)
        `AEQC_ADDR_FILTER: begin
          next_s.upper = reg_wdata[`AEQC_UPPER_MSB:`AEQC_UPPER_LSB];
          next_s.lower = reg_wdata[`AEQC_LOWER_MSB:`AEQC_LOWER_LSB];
        end
        `AEQC_ADDR_CTL: begin
          next_s.err_sel = reg_wdata[`AEQC_ERRSEL_MSB:`AEQC_ERRSEL_LSB];
          next_s.order = reg_wdata[`AEQC_ORDER_BIT];
          next_s.two_step = reg_wdata[`AEQC_TWO_STEP_BIT];
          next_s.nesting = reg_wdata[`AEQC_NESTING_BIT];
          next_s.sweep_en = reg_wdata[`AEQC_SWEEP_EN_BIT];
        end
        `AEQC_ADDR_THRESH: begin
          next_s.threshold = reg_wdata;
        end
        default: begin
          next_s.rdata = s.rdata; // reserved and unmapped writes dropped
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `AEQC_ADDR_FILTER: next_s.rdata = {s.upper, s.lower};
        `AEQC_ADDR_CTL: next_s.rdata = {1'h0, s.err_sel, s.order, s.two_step, s.nesting, s.sweep_en};
        `AEQC_ADDR_THRESH: next_s.rdata = s.threshold;
        default: next_s.rdata = 8'h00; // reserved space reads zero
      endcase
    end
  end

  // state register with reset values
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s.upper <= `AEQC_UPPER_RST;
      s.lower <= `AEQC_LOWER_RST;
      s.err_sel <= `AEQC_ERRSEL_RST;
      s.order <= `AEQC_ORDER_RST;
      s.two_step <= `AEQC_TWO_STEP_RST;
      s.nesting <= `AEQC_NESTING_RST;
      s.sweep_en <= `AEQC_SWEEP_EN_RST;
      s.threshold <= `AEQC_THRESH_RST;
      s.rdata <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign phase_filter_upper_limit = s.upper;
  assign phase_filter_lower_limit = s.lower;
  assign adapt_error_check_select = s.err_sel;
  assign filter_sweep_order = s.order;
  assign two_step_validation_enable = s.two_step;
  assign loop_nesting_select = s.nesting;
  assign filter_sweep_enable = s.sweep_en;
  assign adapt_error_threshold = s.threshold;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  a_limit_reset_values: assert property (@(posedge core_clk) $past(rst) && !rst |->
    s.upper == 4'ha && s.lower == 4'h9) else $error("filter limits not at reset values");
  a_ctl_reset_values: assert property (@(posedge core_clk) $past(rst) && !rst |->
    s.err_sel == 3'h7 && s.sweep_en && !s.two_step && s.threshold == 8'h01) else $error("control reset wrong");
  a_reserved_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && (reg_addr == 8'h40 || reg_addr > 8'h43) |=> reg_rdata == 8'h00) else $error("reserved read nonzero");
endmodule

// ==== src/aeqc_err_acc.sv ====
// link error accumulator with threshold compare
`timescale 1ns/1ps
module aeqc_err_acc (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic window_end,
  input wire logic [2:0] err_vec,
  input wire logic [2:0] err_select,
  input wire logic [7:0] threshold,
  output logic err_seen,
  output logic over_threshold,
  output logic [7:0] err_count
);
  aeqc_pkg::aeqc_acc_t s;
  aeqc_pkg::aeqc_acc_t next_s;
  logic [8:0] total;

  // any selected error in this cycle
  assign err_seen = |(err_vec & err_select);
  assign total = {1'h0, s.count} + {8'h00, err_seen};

  // -------------------------------------------------------------------
  // count over the window, compare at its end
  // -------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.over = 1'h0;
    if (clear) begin
      next_s.count = 8'h00;
    end else if (window_end) begin
      next_s.over = (err_select != 3'h0) && (total > {1'h0, threshold});
      next_s.count = 8'h00;
    end else if (err_seen && s.count != 8'hff) begin
      next_s.count = total[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign over_threshold = s.over;
  assign err_count = s.count;

  a_over_needs_window: assert property (@(posedge core_clk) disable iff (rst)
    over_threshold |-> $past(window_end) && !$past(clear)) else $error("threshold flag outside window end");
  a_threshold_compare: assert property (@(posedge core_clk) disable iff (rst)
    window_end && !clear && err_select != 3'h0 && err_count > threshold |=> over_threshold)
    else $error("count above threshold not flagged");
endmodule

// ==== testbench/aeqc_ser_model.sv ====
// remote serializer model: lock indication and link error pulses
`timescale 1ns/1ps
module aeqc_ser_model (
  input wire logic core_clk,
  input wire logic [3:0] eq_setting,
  input wire logic [3:0] lock_min,
  input wire logic [2:0] err_req,
  output logic link_lock,
  output logic err_clock_bit,
  output logic err_sequence,
  output logic err_parity
);
  // link locks once the equalizer is strong enough; requested errors show one cycle later
  always_ff @(posedge core_clk) begin
    link_lock <= eq_setting >= lock_min;
    {err_clock_bit, err_sequence, err_parity} <= err_req;
  end
endmodule

// ==== testbench/adaptive_equalizer_control_bench.sv ====
// self-checking bench of the adaptive equalizer control block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module adaptive_equalizer_control_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [19:0] relock_period = 20'h00008;
  logic adapt_start = 1'b0;
  logic link_lock, err_clock_bit, err_sequence, err_parity, adapt_busy, adapt_locked;
  logic [3:0] eq_setting, sample_phase_filter, fmin, fmax;
  logic [3:0] lock_min = 4'h0;
  logic [2:0] err_req = 3'h0;
  logic [7:0] rv;
  int miscompares = 0;
  int num_checks = 0;
  // rows: write flag, address, write data, expected read
  logic [24:0] rows [11] = '{25'h0400000, 25'h04100a9, 25'h0420071, 25'h0430001, 25'h0440000,
    25'h140ff00, 25'h142ff7f, 25'h141c2c2, 25'h1430404, 25'h145ff00, 25'h1430101};

  aeqc_top u_aeqc_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .relock_period(relock_period),
    .adapt_start(adapt_start), .link_lock(link_lock), .err_clock_bit(err_clock_bit),
    .err_sequence(err_sequence), .err_parity(err_parity), .eq_setting(eq_setting),
    .sample_phase_filter(sample_phase_filter), .adapt_busy(adapt_busy), .adapt_locked(adapt_locked));
  aeqc_ser_model u_aeqc_ser_model (.core_clk(core_clk), .eq_setting(eq_setting), .lock_min(lock_min),
    .err_req(err_req), .link_lock(link_lock), .err_clock_bit(err_clock_bit),
    .err_sequence(err_sequence), .err_parity(err_parity));

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // bus cycles, waits and stimulus helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic start;
    @(posedge core_clk);
    adapt_start <= 1'b1;
    @(posedge core_clk);
    adapt_start <= 1'b0;
    #1;
  endtask
  task automatic errs(input int k, input int n);
    repeat (n) begin
      @(posedge core_clk);
      err_req <= 3'(1 << k);
      @(posedge core_clk);
      err_req <= 3'h0;
    end
    #1;
  endtask
  task automatic run(input int n);
    fmin = 4'hf;
    fmax = 4'h0;
    repeat (n) begin
      cyc(1);
      if (sample_phase_filter < fmin) fmin = sample_phase_filter;
      if (sample_phase_filter > fmax) fmax = sample_phase_filter;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    wrap_up;
  end

  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    `CHK({sample_phase_filter, eq_setting, adapt_busy, adapt_locked}, 10'h240)
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rv);
      `CHK(rv, rows[i][7:0])
    end
    $display("register table done");
    wr(8'h42, 8'h79);
    start;
    `CHK({sample_phase_filter, eq_setting, adapt_busy}, 9'h0e1)
    wr(8'h42, 8'h71);
    start;
    `CHK(sample_phase_filter, 4'hc)
    cyc(7);
    `CHK(adapt_locked, 1'b0)
    cyc(1);
    `CHK({adapt_locked, adapt_busy}, 2'b10)
    wr(8'h42, 8'h75);
    start;
    cyc(7);
    `CHK({adapt_locked, adapt_busy}, 2'b01)
    cyc(3);
    `CHK(adapt_locked, 1'b1)
    start;
    cyc(4);
    errs(0, 1);
    cyc(3);
    `CHK({eq_setting, adapt_locked}, 5'h02)
    $display("start and validation done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h42, {1'b0, 3'(1 << k), 4'h1});
      start;
      cyc(10);
      errs((k + 1) % 3, 3);
      cyc(12);
      `CHK(eq_setting, 4'h0)
      errs(k, 3);
      cyc(8);
      `CHK(eq_setting, 4'h1)
    end
    $display("error threshold done");
    @(posedge core_clk);
    relock_period <= 20'h00002;
    lock_min <= 4'hf;
    wr(8'h41, 8'h31); // upper limit kept at or above lower
    wr(8'h42, 8'h73);
    start;
    run(24);
    `CHK({fmin, fmax, eq_setting > 4'h0}, 9'h027)
    wr(8'h42, 8'h7b);
    start;
    cyc(2);
    `CHK(sample_phase_filter, 4'h1)
    wr(8'h42, 8'h71);
    start;
    run(20);
    `CHK({fmin, fmax, eq_setting > 4'h3}, 9'h067)
    wr(8'h42, 8'h70);
    start;
    run(40);
    `CHK(fmin, fmax)
    $display("sweep nesting done");
    @(posedge core_clk);
    rst <= 1'b1;
    cyc(2);
    @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    `CHK({eq_setting, adapt_busy, adapt_locked}, 6'h00)
    rd(8'h42, rv);
    `CHK(rv, 8'h71)
    $display("mid-run reset done");
    wrap_up;
  end
endmodule
